// ===== scs_clock_switch.sv
// module: system clock switch controller with key lock and APB registers
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module scs_clock_switch (
  input wire logic pclk,
  input wire logic presetn,
  input wire scs_pkg::scs_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] config_word_one,
  input wire scs_pkg::scs_osc_stat_t osc_stat,
  output scs_pkg::scs_osc_ctl_t osc_ctl,
  output logic [31:0] guarded_ctrl,
  output logic [2:0] current_source_stat,
  output logic system_write_lock
);
  import scs_pkg::*;

  function automatic logic [1:0] src_osc(input logic [2:0] src);
    case (src)
      SRC_PRIMARY, SRC_PRIMARY_PLL: src_osc = OSC_PRIMARY;
      SRC_SECONDARY: src_osc = OSC_SECONDARY;
      SRC_LOW_POWER_RC: src_osc = OSC_LOW_POWER_RC;
      default: src_osc = OSC_FAST_RC;
    endcase
  endfunction

  function automatic logic src_pll(input logic [2:0] src);
    src_pll = (src == SRC_FAST_RC_PLL) || (src == SRC_PRIMARY_PLL);
  endfunction

  function automatic logic src_xtal(input logic [2:0] src,
                                    input logic [1:0] mode);
    src_xtal = (src_osc(src) == OSC_SECONDARY) ||
               ((src_osc(src) == OSC_PRIMARY) && (mode != SUBMODE_EXT_CLK));
  endfunction

  // two-stage synchronisers for pins and configuration fuses
  scs_osc_stat_t stat_m_r;
  scs_osc_stat_t stat_s_r;
  logic [31:0] cfg_m_r;
  logic [31:0] cfg_s_r;
  logic [1:0] boot_r;
  logic boot_seen_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_m_r <= '0;
      stat_s_r <= '0;
      cfg_m_r <= CFG_RESET;
      cfg_s_r <= CFG_RESET;
      boot_r <= '0;
      boot_seen_r <= 1'b0;
    end else begin
      stat_m_r <= osc_stat;
      stat_s_r <= stat_m_r;
      cfg_m_r <= config_word_one;
      cfg_s_r <= cfg_m_r;
      boot_seen_r <= (boot_r == BOOT_FILL);
      if (boot_r != BOOT_FILL) begin
        boot_r <= boot_r + GAP_ONE;
      end
    end
  end

  wire boot_done = (boot_r == BOOT_FILL);
  // defaults load once, after the second sync stage holds real fuse values
  wire boot_load = boot_done & ~boot_seen_r;
  wire sw_en = ~cfg_s_r[CFG_SW_DIS_BIT] & boot_done;
  wire [2:0] dflt_src = cfg_s_r[CFG_DFLT_MSB:CFG_DFLT_LSB];
  // submode comes only from configuration; no register bit reaches it
  wire [1:0] submode = cfg_s_r[CFG_SUBMODE_MSB:CFG_SUBMODE_LSB];
  wire fail_evt = stat_s_r.fail & sw_en;

  // apb slave: answers in the first access cycle
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic locked_r;
  logic key1_r;
  logic req_r;
  logic [2:0] new_r;
  logic [2:0] cur_r;
  logic [2:0] tgt_r;
  logic [31:0] guard_r;
  scs_state_t state_r;
  scs_state_t state_nxt;
  logic [STARTUP_W-1:0] startup_cnt_r;

  wire setup = apb_req.psel & ~apb_req.penable;
  wire access = apb_req.psel & apb_req.penable & pready_r;
  wire hit_ctrl = (apb_req.paddr == ADDR_CTRL);
  wire hit_key = (apb_req.paddr == ADDR_KEY);
  wire hit_guard = (apb_req.paddr == ADDR_GUARD);
  wire mapped = hit_ctrl | hit_key | hit_guard;
  wire key_wr = access & apb_req.pwrite & hit_key;
  wire other_acc = access & ~key_wr;
  wire is_key1 = (apb_req.pwdata == KEY_ONE);
  wire is_key2 = (apb_req.pwdata == KEY_TWO);
  wire ctrl_wr = access & apb_req.pwrite & hit_ctrl & ~locked_r;
  wire guard_wr = access & apb_req.pwrite & hit_guard & ~locked_r;
  wire [2:0] wr_src = apb_req.pwdata[NEW_MSB:NEW_LSB];
  wire sw_req_set = ctrl_wr & sw_en & apb_req.pwdata[REQ_BIT];
  wire sw_req_clr = ctrl_wr & ~apb_req.pwdata[REQ_BIT];

  logic [31:0] ctrl_rd;
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[CUR_MSB:CUR_LSB] = cur_r;
    ctrl_rd[NEW_MSB:NEW_LSB] = new_r;
    ctrl_rd[LOCK_BIT] = locked_r;
    ctrl_rd[REQ_BIT] = req_r;
  end

  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd : (hit_guard ? guard_r : '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r <= setup ? rd_mux : '0;
    end
  end

  // key lock: any access other than the second key breaks the pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_r <= 1'b1;
      key1_r <= 1'b0;
    end else if (key_wr) begin
      if (key1_r && is_key2) begin
        locked_r <= 1'b0;
        key1_r <= 1'b0;
      end else if (key1_r) begin
        locked_r <= 1'b1;
        key1_r <= 1'b0;
      end else if (is_key1) begin
        key1_r <= 1'b1;
      end else if (!is_key2) begin
        locked_r <= 1'b1;
      end
    end else if (other_acc) begin
      key1_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_r <= GUARD_RESET;
    end else if (guard_wr) begin
      guard_r <= apb_req.pwdata;
    end
  end

  // switch sequencer; the cpu clock never stalls while it waits
  wire busy = (state_r != ST_IDLE);
  wire [1:0] tgt_osc = src_osc(tgt_r);
  wire tgt_xtal = src_xtal(tgt_r, submode);
  wire tgt_ready = stat_s_r.ready[tgt_osc];
  wire timer_ok = ~tgt_xtal | (startup_cnt_r == STARTUP_CYCLES);
  wire pll_ok = ~src_pll(tgt_r) | stat_s_r.pll_lock;
  // completion is held off while asleep and taken up on wake
  wire start_ok = tgt_ready & timer_ok & pll_ok & ~stat_s_r.sleep;
  wire sw_hit = sw_req_set | sw_req_clr;
  wire redundant = (tgt_r == cur_r);
  wire pll_to_pll = src_pll(tgt_r) & src_pll(cur_r);
  wire check_drop = (state_r == ST_CHECK) & (redundant | pll_to_pll);
  wire commit = (state_r == ST_START) & start_ok & ~sw_hit & ~fail_evt &
                sw_en;
  wire hw_clr = (check_drop & ~sw_hit) | commit;

  always_comb begin
    state_nxt = state_r;
    if (!sw_en || fail_evt) begin
      state_nxt = ST_IDLE;
    end else if (sw_req_set) begin
      state_nxt = ST_CHECK;
    end else if (sw_req_clr) begin
      state_nxt = ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: state_nxt = ST_IDLE;
        ST_CHECK: state_nxt = check_drop ? ST_IDLE : ST_START;
        ST_START: state_nxt = commit ? ST_IDLE : ST_START;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // a software set wins over a hardware clear in the same cycle
  wire req_nxt = (!sw_en || fail_evt) ? 1'b0 :
                 sw_req_set ? 1'b1 :
                 (sw_req_clr || hw_clr) ? 1'b0 : req_r;
  wire [2:0] cur_nxt = (boot_load || (boot_done && !sw_en)) ? dflt_src :
                       fail_evt ? SRC_FAST_RC :
                       commit ? tgt_r : cur_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      req_r <= 1'b0;
      new_r <= SRC_FAST_RC;
      tgt_r <= SRC_FAST_RC;
      cur_r <= SRC_FAST_RC;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      cur_r <= cur_nxt;
      if (ctrl_wr) begin
        new_r <= wr_src;
      end
      if (sw_req_set) begin
        tgt_r <= wr_src;
      end
    end
  end

  // start-up timer counts only while the target runs; aborts reset it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_cnt_r <= '0;
    end else if (state_nxt != ST_START || !tgt_ready) begin
      startup_cnt_r <= '0;
    end else if (startup_cnt_r != STARTUP_CYCLES) begin
      startup_cnt_r <= startup_cnt_r + STARTUP_ONE;
    end
  end

  // break-before-make mux: gate off, settle, change select, settle, gate on
  logic [2:0] mux_sel_r;
  logic mux_gate_r;
  logic [1:0] gap_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_sel_r <= SRC_FAST_RC;
      mux_gate_r <= 1'b0;
      gap_r <= '0;
    end else if (mux_sel_r != cur_r) begin
      if (mux_gate_r) begin
        mux_gate_r <= 1'b0;
        gap_r <= '0;
      end else if (gap_r == GAP_CYCLES) begin
        mux_sel_r <= cur_r;
        gap_r <= '0;
      end else begin
        gap_r <= gap_r + GAP_ONE;
      end
    end else if (!mux_gate_r) begin
      if (gap_r == GAP_CYCLES) begin
        mux_gate_r <= 1'b1;
        gap_r <= '0;
      end else begin
        gap_r <= gap_r + GAP_ONE;
      end
    end
  end

  // oscillator enables: current, mux, pending target, or another user
  logic [3:0] osc_en_nxt;
  logic [3:0] osc_en_r;
  logic pll_en_r;
  logic wait_hold_r;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_osc
      assign osc_en_nxt[g] = (src_osc(cur_r) == 2'(g)) ||
                             (src_osc(mux_sel_r) == 2'(g)) ||
                             (busy && (tgt_osc == 2'(g))) ||
                             stat_s_r.in_use[g];
    end
  endgenerate

  wire pll_en_nxt = src_pll(cur_r) | src_pll(mux_sel_r) |
                    (busy & src_pll(tgt_r));
  wire wait_hold_nxt = (state_nxt != ST_IDLE) &
                       (stat_s_r.sleep | wait_hold_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en_r <= 4'h1;
      pll_en_r <= 1'b0;
      wait_hold_r <= 1'b0;
    end else begin
      osc_en_r <= osc_en_nxt;
      pll_en_r <= pll_en_nxt;
      wait_hold_r <= wait_hold_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign guarded_ctrl = guard_r;
  assign current_source_stat = cur_r;
  assign system_write_lock = locked_r;
  assign osc_ctl = {osc_en_r, pll_en_r, mux_sel_r, mux_gate_r, wait_hold_r};

  a_req_held_low: assert property (@(posedge pclk) disable iff (!presetn)
    !sw_en |=> !req_r) else $error("request bit set while switching disabled");
  a_locked_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    (locked_r && access && apb_req.pwrite && hit_ctrl) |=> $stable(new_r))
    else $error("control written while locked");
  a_guard_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (locked_r && access && apb_req.pwrite && hit_guard) |=> $stable(guard_r))
    else $error("guarded register written while locked");

  // key lock
  a_unlock_pair: assert property (@(posedge pclk) disable iff (!presetn)
    (key_wr && is_key2 && key1_r) |=> !locked_r)
    else $error("key pair did not unlock");
  a_pair_break: assert property (@(posedge pclk) disable iff (!presetn)
    other_acc |=> !key1_r) else $error("key pair survived another access");
  a_relock_key: assert property (@(posedge pclk) disable iff (!presetn)
    (key_wr && !is_key1 && !is_key2) |=> locked_r)
    else $error("non-key write did not lock");
  a_stay_open: assert property (@(posedge pclk) disable iff (!presetn)
    (!locked_r && !key_wr) |=> !locked_r) else $error("lock closed by itself");

  // switch sequencer
  a_disabled_dflt: assert property (@(posedge pclk)
    disable iff (!presetn)
    (boot_done && !sw_en) |=> (cur_r == $past(dflt_src)))
    else $error("current source does not follow default");
  a_redundant_drop: assert property (@(posedge pclk)
    disable iff (!presetn)
    (state_r == ST_CHECK && redundant && !sw_hit && !fail_evt && sw_en)
    |=> (!req_r && state_r == ST_IDLE && $stable(cur_r)))
    else $error("redundant switch not dropped");
  a_commit_copy: assert property (@(posedge pclk) disable iff (!presetn)
    commit |=> (cur_r == $past(tgt_r) && !req_r))
    else $error("switch completion did not update status");
  a_timer_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && tgt_xtal) |-> ($past(startup_cnt_r) != '0 &&
    startup_cnt_r == STARTUP_CYCLES)) else $error("crystal not timed");
  a_pll_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_START && src_pll(tgt_r) && !stat_s_r.pll_lock &&
    sw_en && !fail_evt) |=> $stable(cur_r))
    else $error("switch completed without pll lock");
  a_pll_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_CHECK && pll_to_pll && !sw_hit && !fail_evt && sw_en)
    |=> (!req_r && $stable(cur_r))) else $error("pll to pll switch allowed");
  a_restart_new: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && sw_req_set && !fail_evt) |=>
    (state_r == ST_CHECK && tgt_r == $past(wr_src) && req_r))
    else $error("new request did not restart the switch");
  a_fail_force: assert property (@(posedge pclk) disable iff (!presetn)
    fail_evt |=> (cur_r == SRC_FAST_RC && !req_r))
    else $error("clock failure did not force fast rc");
  a_abort_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && sw_req_clr && sw_en && !fail_evt) |=>
    (state_r == ST_IDLE && startup_cnt_r == '0 && !req_r))
    else $error("abort did not stop the switch");
  a_pll_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && sw_req_clr && !src_pll(cur_r) && !src_pll(mux_sel_r))
    |=> ##1 !pll_en_r) else $error("pll left running after abort");

  // sleep, oscillators and mux
  a_sleep_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_START && stat_s_r.sleep && sw_en && !fail_evt)
    |=> $stable(cur_r)) else $error("switch completed during sleep");
  a_hold_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && stat_s_r.sleep && state_nxt != ST_IDLE) |=> wait_hold_r)
    else $error("wait completion not held during sleep");
  a_wait_free: assert property (@(posedge pclk) disable iff (!presetn)
    (state_nxt == ST_IDLE) |=> !wait_hold_r)
    else $error("wait completion held with no switch pending");
  a_osc_start: assert property (@(posedge pclk) disable iff (!presetn)
    busy |=> osc_en_r[$past(tgt_osc)])
    else $error("target oscillator not enabled");
  a_mux_break: assert property (@(posedge pclk) disable iff (!presetn)
    (mux_sel_r != $past(mux_sel_r)) |-> (!mux_gate_r && !$past(mux_gate_r)
    && !$past(mux_gate_r, 2))) else $error("mux select changed while gated");
endmodule // scs_clock_switch

// ===== scs_pkg.sv
// package: register map, field layout, constants and types of the clock switch
// Summary of operation
// - switching allowed only while config word bit 15 is programmed low
// - switching disabled: new source ignored, current source follows default
// - switching disabled: switch request bit held zero, writes ignored
// - control register writes rejected while the write lock is closed
// - unlock needs first key then second key, nothing in between
// - any non-key value written to the key register closes the lock
// - lock never closes by itself; unlocking also opens the guarded register
// - software loads new source, then sets switch request to start
// - request equal to current source is cleared and dropped
// - target oscillator turned on; crystals wait for start-up timer
// - PLL targets wait for PLL lock before completing
// - on success request clears and new source copies to current
// - old oscillator turned off unless another module still uses it
// - oscillator that never becomes ready leaves request set, old clock kept
// - direct switch between two PLL sources refused
// - software clearing request aborts switch, resets timer, stops PLL
// - new request during pending switch aborts the old one
// - sleep keeps switch pending; wait completes only after switch finishes
// - primary submode fixed by configuration only, never by software
// - new source code 7 selects fast RC oscillator with divider
// - processor keeps running on old clock during a pending switch
// - with switching enabled, clock failure forces current source 000 and cancels request
package scs_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_KEY = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_GUARD = 8'h08;
  localparam int REQ_BIT = 0;
  localparam int LOCK_BIT = 4;
  localparam int NEW_LSB = 8;
  localparam int NEW_MSB = 10;
  localparam int CUR_LSB = 12;
  localparam int CUR_MSB = 14;
  localparam int CFG_SW_DIS_BIT = 15;
  localparam int CFG_DFLT_LSB = 0;
  localparam int CFG_DFLT_MSB = 2;
  localparam int CFG_SUBMODE_LSB = 8;
  localparam int CFG_SUBMODE_MSB = 9;
  localparam logic [31:0] CFG_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] KEY_ONE = 32'hAA99_6655;
  localparam logic [31:0] KEY_TWO = 32'h5566_99AA;
  localparam logic [31:0] GUARD_RESET = 32'h0000_0000;
  localparam logic [2:0] SRC_FAST_RC = 3'h0;
  localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRIMARY = 3'h2;
  localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
  localparam logic [2:0] SRC_FAST_RC_DIV = 3'h7;
  localparam logic [1:0] OSC_FAST_RC = 2'h0;
  localparam logic [1:0] OSC_PRIMARY = 2'h1;
  localparam logic [1:0] OSC_SECONDARY = 2'h2;
  localparam logic [1:0] OSC_LOW_POWER_RC = 2'h3;
  localparam logic [1:0] SUBMODE_EXT_CLK = 2'h0;
  localparam int STARTUP_W = 11;
  localparam logic [STARTUP_W-1:0] STARTUP_CYCLES = 11'h400;
  localparam logic [STARTUP_W-1:0] STARTUP_ONE = 11'h001;
  localparam logic [1:0] GAP_CYCLES = 2'h2;
  localparam logic [1:0] GAP_ONE = 2'h1;
  localparam logic [1:0] BOOT_LAST = 2'h1;
  localparam logic [1:0] BOOT_FILL = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_START} scs_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } scs_apb_req_t;

  typedef struct packed {
    logic [3:0] ready;
    logic [3:0] in_use;
    logic pll_lock;
    logic fail;
    logic sleep;
  } scs_osc_stat_t;

  typedef struct packed {
    logic [3:0] osc_en;
    logic pll_en;
    logic [2:0] mux_sel;
    logic mux_gate;
    logic wait_hold;
  } scs_osc_ctl_t;
endpackage

// ===== scs_clock_switch_tb_top.sv
// testbench: register table loop, then hand-written switch scenarios
`timescale 1ns/1ps
module scs_clock_switch_tb_top;
  import scs_pkg::*;
  typedef struct packed {
    logic w;
    logic [ADDR_W-1:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic err;
  } scs_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  scs_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] cfg = 32'hFFFF_7FF8;
  scs_osc_stat_t st = '{ready: 4'h9, default: '0};
  scs_osc_ctl_t osc_ctl;
  logic [31:0] guarded_ctrl;
  logic [2:0] current_source_stat;
  logic system_write_lock;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic err;
  int n;
  scs_row_t rows [25] = '{
    '{1'b1, ADDR_CTRL, 32'h0000_0401, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0000_0010, 1'b0},
    '{1'b1, ADDR_GUARD, 32'hA5A5_A5A5, 32'h0, 1'b0},
    '{1'b0, ADDR_GUARD, 32'h0, 32'h0, 1'b0},
    '{1'b1, ADDR_KEY, KEY_TWO, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0000_0010, 1'b0},
    '{1'b1, ADDR_KEY, KEY_ONE, 32'h0, 1'b0},
    '{1'b1, ADDR_KEY, KEY_TWO, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b1, ADDR_GUARD, 32'h1234_5678, 32'h0, 1'b0},
    '{1'b0, ADDR_GUARD, 32'h0, 32'h1234_5678, 1'b0},
    '{1'b0, ADDR_KEY, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1},
    '{1'b1, ADDR_KEY, KEY_ONE, 32'h0, 1'b0},
    '{1'b1, ADDR_KEY, 32'h0000_0001, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0000_0010, 1'b0},
    '{1'b1, ADDR_KEY, KEY_ONE, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0000_0010, 1'b0},
    '{1'b1, ADDR_KEY, KEY_TWO, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0000_0010, 1'b0},
    '{1'b1, ADDR_KEY, KEY_ONE, 32'h0, 1'b0},
    '{1'b1, ADDR_KEY, KEY_TWO, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b1, ADDR_KEY, 32'h3333_3333, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0000_0010, 1'b0}
  };

`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end

  always #2 pclk = ~pclk;

  scs_clock_switch u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .config_word_one(cfg),
    .osc_stat(st),
    .osc_ctl(osc_ctl),
    .guarded_ctrl(guarded_ctrl),
    .current_source_stat(current_source_stat),
    .system_write_lock(system_write_lock)
  );

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic sw(input logic [2:0] src, input logic go);
    apb(1'b1, ADDR_CTRL, {21'h0, src, 7'h0, go});
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic wait_cur(input logic [2:0] e, input int lim);
    n = 0;
    while (current_source_stat !== e && n < lim) begin
      @(posedge pclk);
      n++;
    end
    `CHK("current_source_stat", e, current_source_stat)
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    idle(5);
    `CHK("system_write_lock", 1'b1, system_write_lock)
    `CHK("osc_en", 4'h1, osc_ctl.osc_en)
    `CHK("current_source_stat", 3'h0, current_source_stat)
    `CHK("pready", 1'b0, pready)
    presetn <= 1'b1;
    idle(4);
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    $display("[FAIL] watchdog exp done got timeout");
    tally_and_finish;
  end

  initial begin
    do_reset;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK("pslverr", rows[i].err, err)
      if (!rows[i].w)
        `CHK("prdata", rows[i].e, rd)
    end
    `CHK("guarded_ctrl", 32'h1234_5678, guarded_ctrl)
    `CHK("system_write_lock", 1'b1, system_write_lock)
    $display("test register table done");
    apb(1'b1, ADDR_KEY, KEY_ONE);
    apb(1'b1, ADDR_KEY, KEY_TWO);
    sw(SRC_FAST_RC, 1'b1);
    idle(4);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("request", 1'b0, rd[REQ_BIT])
    $display("test redundant done");
    sw(SRC_PRIMARY, 1'b1);
    idle(200);
    `CHK("osc_en primary", 1'b1, osc_ctl.osc_en[1])
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("request", 1'b1, rd[REQ_BIT])
    `CHK("current", 3'h0, rd[CUR_MSB:CUR_LSB])
    st.ready[1] <= 1'b1;
    wait_cur(SRC_PRIMARY, 1300);
    `CHK("startup wait", 1'b1, n >= 1024)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("request", 1'b0, rd[REQ_BIT])
    `CHK("current", SRC_PRIMARY, rd[CUR_MSB:CUR_LSB])
    idle(20);
    `CHK("osc_en fast rc", 1'b0, osc_ctl.osc_en[0])
    `CHK("mux_sel", SRC_PRIMARY, osc_ctl.mux_sel)
    `CHK("mux_gate", 1'b1, osc_ctl.mux_gate)
    $display("test crystal switch done");
    sw(SRC_FAST_RC_PLL, 1'b1);
    idle(10);
    `CHK("pll_en", 1'b1, osc_ctl.pll_en)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("request", 1'b1, rd[REQ_BIT])
    sw(SRC_FAST_RC_PLL, 1'b0);
    idle(4);
    `CHK("pll_en", 1'b0, osc_ctl.pll_en)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("request", 1'b0, rd[REQ_BIT])
    `CHK("current", SRC_PRIMARY, rd[CUR_MSB:CUR_LSB])
    st.pll_lock <= 1'b1;
    sw(SRC_FAST_RC_PLL, 1'b1);
    wait_cur(SRC_FAST_RC_PLL, 100);
    sw(SRC_PRIMARY_PLL, 1'b1);
    idle(6);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("request", 1'b0, rd[REQ_BIT])
    `CHK("current", SRC_FAST_RC_PLL, rd[CUR_MSB:CUR_LSB])
    $display("test pll done");
    sw(SRC_SECONDARY, 1'b1);
    idle(10);
    sw(SRC_LOW_POWER_RC, 1'b1);
    wait_cur(SRC_LOW_POWER_RC, 100);
    st.sleep <= 1'b1;
    sw(SRC_FAST_RC_DIV, 1'b1);
    idle(30);
    `CHK("current", SRC_LOW_POWER_RC, current_source_stat)
    `CHK("wait_hold", 1'b1, osc_ctl.wait_hold)
    st.sleep <= 1'b0;
    wait_cur(SRC_FAST_RC_DIV, 100);
    idle(4);
    `CHK("wait_hold", 1'b0, osc_ctl.wait_hold)
    $display("test abort and sleep done");
    sw(SRC_SECONDARY, 1'b1);
    idle(10);
    st.fail <= 1'b1;
    idle(6);
    `CHK("current", SRC_FAST_RC, current_source_stat)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("request", 1'b0, rd[REQ_BIT])
    st.fail <= 1'b0;
    st.in_use[OSC_LOW_POWER_RC] <= 1'b1;
    idle(300);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("lock bit", 1'b0, rd[LOCK_BIT])
    `CHK("osc_en low power rc", 1'b1, osc_ctl.osc_en[3])
    `CHK("osc_en secondary", 1'b0, osc_ctl.osc_en[2])
    $display("test failure and no relock done");
    cfg <= 32'hFFFF_7CF8;
    idle(3);
    sw(SRC_PRIMARY, 1'b1);
    wait_cur(SRC_PRIMARY, 100);
    $display("test external clock done");
    cfg <= 32'hFFFF_FFFD;
    do_reset;
    `CHK("current", SRC_LOW_POWER_RC, current_source_stat)
    apb(1'b1, ADDR_KEY, KEY_ONE);
    apb(1'b1, ADDR_KEY, KEY_TWO);
    sw(SRC_PRIMARY, 1'b1);
    idle(4);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("request", 1'b0, rd[REQ_BIT])
    `CHK("current", SRC_LOW_POWER_RC, rd[CUR_MSB:CUR_LSB])
    $display("test switching disabled done");
    tally_and_finish;
  end
endmodule // scs_clock_switch_tb_top
